//--- rtl/acd_top.sv
// Purpose: Clock divider configuration registers and divider tree
// Assumes: Register port already decoded from the control interface
// Notes:   Auto detection supplies its own ratios when enabled
`timescale 1ns/1ps
`default_nettype none
`include "acd_cfg.svh"

module acd_top #(
  parameter int RW = 10
) (
  input  wire logic                       mclk,
  input  wire logic                       reset_n,
  input  wire logic                       clk_en,
  input  wire acd_pkg::acd_req_t          req,
  output logic [7:0]                      rdata,
  output logic                            rvalid,
  input  wire logic                       auto_detect_en,
  input  wire logic [acd_pkg::ACD_CH*RW-1:0] auto_ratio,
  output logic [acd_pkg::ACD_CH-1:0]      div_tick,
  output logic [acd_pkg::ACD_CH-1:0]      div_clk,
  output logic [acd_pkg::ACD_CH*RW-1:0]   div_ratio
);
  import acd_pkg::*;

  logic [7:0] n_pdm;
  logic [7:0] m_adc;
  logic [7:0] dac_msb;
  logic [7:0] pb_low;
  logic [7:0] sb_low;
  logic [7:0] en_nmp;
  logic [7:0] en_mod;

  logic [2:0] n_stage_divider;
  logic [2:0] pulse_density_clock_divider;
  logic [5:0] m_stage_divider;
  logic [1:0] adc_modulator_clock_divider;
  logic [1:0] dac_modulator_clock_divider;
  logic [8:0] primary_bitclk_code;
  logic [8:0] secondary_bitclk_code;

  logic [ACD_CH*RW-1:0] cfg_ratio;
  logic [ACD_CH-1:0]    cfg_ok;
  logic [ACD_CH-1:0]    ch_en;

  // ---------------------------------------------
  // Register store
  // ---------------------------------------------
  acd_regs acd_regs_inst (
    .mclk    (mclk),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .req     (req),
    .rdata   (rdata),
    .rvalid  (rvalid),
    .n_pdm   (n_pdm),
    .m_adc   (m_adc),
    .dac_msb (dac_msb),
    .pb_low  (pb_low),
    .sb_low  (sb_low),
    .en_nmp  (en_nmp),
    .en_mod  (en_mod)
  );

  // ---------------------------------------------
  // Field extraction
  // ---------------------------------------------
  assign n_stage_divider             = n_pdm[`ACD_N_HI:`ACD_N_LO];
  assign pulse_density_clock_divider = n_pdm[`ACD_PDM_HI:`ACD_PDM_LO];
  assign m_stage_divider             = m_adc[`ACD_M_HI:`ACD_M_LO];
  assign adc_modulator_clock_divider = m_adc[`ACD_ADC_HI:`ACD_ADC_LO];
  assign dac_modulator_clock_divider = dac_msb[`ACD_DAC_HI:`ACD_DAC_LO];
  assign primary_bitclk_code   = {dac_msb[`ACD_PMSB_BIT], pb_low};
  assign secondary_bitclk_code = {dac_msb[`ACD_SMSB_BIT], sb_low};

  // ---------------------------------------------
  // Code to ratio mapping
  // ---------------------------------------------
  function automatic logic [RW-1:0] bclk_ratio(input logic [8:0] code);
    bclk_ratio = (code == 9'h000) ? RW'(`ACD_BCLK_ZERO_RATIO) : RW'(code);
  endfunction : bclk_ratio

  always_comb begin
    cfg_ratio = '0;
    cfg_ok    = '1;
    cfg_ratio[ACD_CH_N*RW +: RW] = (n_stage_divider == 3'h0) ?
        RW'(`ACD_N_ZERO_RATIO) : RW'(n_stage_divider);
    cfg_ratio[ACD_CH_M*RW +: RW] = (m_stage_divider == 6'h00) ?
        RW'(`ACD_M_ZERO_RATIO) : RW'(m_stage_divider);
    cfg_ratio[ACD_CH_PDM*RW +: RW] = RW'(1) << pulse_density_clock_divider;
    cfg_ok[ACD_CH_PDM] = (pulse_density_clock_divider <= `ACD_PDM_MAX_CODE);
    cfg_ratio[ACD_CH_ADC*RW +: RW] = RW'(1) << adc_modulator_clock_divider;
    cfg_ok[ACD_CH_ADC] = (adc_modulator_clock_divider <= `ACD_MOD_MAX_CODE);
    cfg_ratio[ACD_CH_DAC*RW +: RW] = RW'(1) << dac_modulator_clock_divider;
    cfg_ok[ACD_CH_DAC] = (dac_modulator_clock_divider <= `ACD_MOD_MAX_CODE);
    cfg_ratio[ACD_CH_PB*RW +: RW] = bclk_ratio(primary_bitclk_code);
    cfg_ratio[ACD_CH_SB*RW +: RW] = bclk_ratio(secondary_bitclk_code);
  end

  // ---------------------------------------------
  // Enables
  // ---------------------------------------------
  assign ch_en[ACD_CH_N]   = en_nmp[`ACD_EN_N_BIT];
  assign ch_en[ACD_CH_M]   = en_nmp[`ACD_EN_M_BIT];
  assign ch_en[ACD_CH_PDM] = en_nmp[`ACD_EN_PDM_BIT];
  assign ch_en[ACD_CH_ADC] = en_mod[`ACD_EN_ADC_BIT];
  assign ch_en[ACD_CH_DAC] = en_mod[`ACD_EN_DAC_BIT];
  assign ch_en[ACD_CH_PB]  = en_mod[`ACD_EN_PB_BIT];
  assign ch_en[ACD_CH_SB]  = en_mod[`ACD_EN_SB_BIT];

  // ---------------------------------------------
  // Divider channels
  // ---------------------------------------------
  genvar g;
  generate
    for (g = 0; g < ACD_CH; g++) begin : g_ch
      logic [RW-1:0] sel;
      logic          ok;
      logic [RW-1:0] ar;
      logic [RW-1:0] ratio_q;
      assign ar  = auto_ratio[g*RW +: RW];
      assign sel = auto_detect_en ? ((ar == '0) ? RW'(1) : ar)
                                  : cfg_ratio[g*RW +: RW];
      assign ok  = auto_detect_en | cfg_ok[g];

      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          ratio_q <= RW'(1);
        end else if (clk_en) begin
          ratio_q <= sel;
        end
      end

      assign div_ratio[g*RW +: RW] = ratio_q;

      acd_div #(.W(RW)) acd_div_inst (
        .mclk    (mclk),
        .reset_n (reset_n),
        .clk_en  (clk_en),
        .run     (ch_en[g] & ok),
        .ratio   (ratio_q),
        .tick    (div_tick[g]),
        .clk_out (div_clk[g])
      );
    end
  endgenerate
endmodule : acd_top
`default_nettype wire

//--- rtl/acd_cfg.svh
// Purpose: Offsets, field positions, reset values and codes for the clock divider block
// Assumes: Byte-wide register port with 8-bit addresses
// Notes:   Definitions only
`ifndef ACD_CFG_SVH
`define ACD_CFG_SVH

`define ACD_OFS_N_PDM        8'h39
`define ACD_OFS_M_ADC        8'h3A
`define ACD_OFS_DAC_MSB      8'h3B
`define ACD_OFS_PBCLK_LOW    8'h3C
`define ACD_OFS_SBCLK_LOW    8'h3D
`define ACD_OFS_EN_NMP       8'h44
`define ACD_OFS_EN_MOD       8'h45

`define ACD_RST_N_PDM        8'h20
`define ACD_RST_M_ADC        8'h04
`define ACD_RST_DAC_MSB      8'h00
`define ACD_RST_PBCLK_LOW    8'h01
`define ACD_RST_SBCLK_LOW    8'h01
`define ACD_RST_EN           8'h00

`define ACD_MASK_N_PDM       8'hFC
`define ACD_MASK_M_ADC       8'hFF
`define ACD_MASK_DAC_MSB     8'h36
`define ACD_MASK_EN_NMP      8'h07
`define ACD_MASK_EN_MOD      8'hFF

`define ACD_N_HI             7
`define ACD_N_LO             5
`define ACD_PDM_HI           4
`define ACD_PDM_LO           2
`define ACD_M_HI             7
`define ACD_M_LO             2
`define ACD_ADC_HI           1
`define ACD_ADC_LO           0
`define ACD_DAC_HI           5
`define ACD_DAC_LO           4
`define ACD_PMSB_BIT         2
`define ACD_SMSB_BIT         1

`define ACD_EN_N_BIT         2
`define ACD_EN_M_BIT         1
`define ACD_EN_PDM_BIT       0
`define ACD_EN_ADC_BIT       6
`define ACD_EN_DAC_BIT       4
`define ACD_EN_PB_BIT        3
`define ACD_EN_SB_BIT        2

`define ACD_N_ZERO_RATIO     10'd8
`define ACD_M_ZERO_RATIO     10'd64
`define ACD_BCLK_ZERO_RATIO  10'd512
`define ACD_PDM_MAX_CODE     3'd4
`define ACD_MOD_MAX_CODE     2'd2

`endif

//--- rtl/acd_pkg.sv
// Purpose: Types for the clock divider block
// Assumes: Ratio fits ten bits
// Notes:   Constants live in acd_cfg.svh
package acd_pkg;
  localparam int ACD_CH = 7;

  typedef logic [9:0] acd_ratio_t;

  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } acd_req_t;

  typedef enum logic [2:0] {
    ACD_CH_N   = 3'h0,
    ACD_CH_M   = 3'h1,
    ACD_CH_PDM = 3'h2,
    ACD_CH_ADC = 3'h3,
    ACD_CH_DAC = 3'h4,
    ACD_CH_PB  = 3'h5,
    ACD_CH_SB  = 3'h6
  } acd_chan_t;
endpackage : acd_pkg

//--- rtl/acd_div.sv
// Purpose: One integer clock divider emitting a one-cycle tick per period
// Assumes: Ratio of at least one
// Notes:   Restarts from zero when disabled
`timescale 1ns/1ps
`default_nettype none
module acd_div #(
  parameter int W = 10
) (
  input  wire logic         mclk,
  input  wire logic         reset_n,
  input  wire logic         clk_en,
  input  wire logic         run,
  input  wire logic [W-1:0] ratio,
  output logic              tick,
  output logic              clk_out
);
  logic [W-1:0] cnt_q;
  logic         last;

  assign last = (cnt_q >= ratio - W'(1));
  assign tick = run & last;

  // ---------------------------------------------
  // Counter
  // ---------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= '0;
    end else if (clk_en) begin
      if (!run || last) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + W'(1);
      end
    end
  end

  // ---------------------------------------------
  // Output clock, high for first half
  // ---------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      clk_out <= 1'b0;
    end else if (clk_en) begin
      if (!run) begin
        clk_out <= 1'b0;
      end else if (ratio == W'(1)) begin
        clk_out <= ~clk_out;
      end else begin
        clk_out <= (last || (cnt_q + W'(1) < (ratio >> 1)));
      end
    end
  end
endmodule : acd_div
`default_nettype wire

//--- rtl/acd_regs.sv
// Purpose: Register store of the clock divider block
// Assumes: One access per cycle
// Notes:   Reserved bits are held at zero and read as zero, except that all eight bits at 8'h45 are stored
`timescale 1ns/1ps
`default_nettype none
module acd_regs (
  input  wire logic              mclk,
  input  wire logic              reset_n,
  input  wire logic              clk_en,
  input  wire acd_pkg::acd_req_t req,
  output logic [7:0]             rdata,
  output logic                   rvalid,
  output logic [7:0]             n_pdm,
  output logic [7:0]             m_adc,
  output logic [7:0]             dac_msb,
  output logic [7:0]             pb_low,
  output logic [7:0]             sb_low,
  output logic [7:0]             en_nmp,
  output logic [7:0]             en_mod
);
  import acd_pkg::*;
  `include "acd_cfg.svh"

  logic [7:0] rd_d;
  logic       hit;

  // ---------------------------------------------
  // Writes, reserved bits masked to zero except at 8'h45 (mask 8'hFF)
  // ---------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      n_pdm   <= `ACD_RST_N_PDM;
      m_adc   <= `ACD_RST_M_ADC;
      dac_msb <= `ACD_RST_DAC_MSB;
      pb_low  <= `ACD_RST_PBCLK_LOW;
      sb_low  <= `ACD_RST_SBCLK_LOW;
      en_nmp  <= `ACD_RST_EN;
      en_mod  <= `ACD_RST_EN;
    end else if (clk_en && req.wr_en) begin
      case (req.addr)
        `ACD_OFS_N_PDM:     n_pdm   <= req.wdata & `ACD_MASK_N_PDM;
        `ACD_OFS_M_ADC:     m_adc   <= req.wdata & `ACD_MASK_M_ADC;
        `ACD_OFS_DAC_MSB:   dac_msb <= req.wdata & `ACD_MASK_DAC_MSB;
        `ACD_OFS_PBCLK_LOW: pb_low  <= req.wdata;
        `ACD_OFS_SBCLK_LOW: sb_low  <= req.wdata;
        `ACD_OFS_EN_NMP:    en_nmp  <= req.wdata & `ACD_MASK_EN_NMP;
        `ACD_OFS_EN_MOD:    en_mod  <= req.wdata & `ACD_MASK_EN_MOD;
        default:            ;
      endcase
    end
  end

  // ---------------------------------------------
  // Read mux
  // ---------------------------------------------
  always_comb begin
    rd_d = 8'h00;
    hit  = 1'b1;
    case (req.addr)
      `ACD_OFS_N_PDM:     rd_d = n_pdm;
      `ACD_OFS_M_ADC:     rd_d = m_adc;
      `ACD_OFS_DAC_MSB:   rd_d = dac_msb;
      `ACD_OFS_PBCLK_LOW: rd_d = pb_low;
      `ACD_OFS_SBCLK_LOW: rd_d = sb_low;
      `ACD_OFS_EN_NMP:    rd_d = en_nmp;
      `ACD_OFS_EN_MOD:    rd_d = en_mod;
      default:            hit  = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdata  <= 8'h00;
      rvalid <= 1'b0;
    end else if (clk_en) begin
      rvalid <= req.rd_en;
      if (req.rd_en) begin
        rdata <= hit ? rd_d : 8'h00;
      end
    end
  end
endmodule : acd_regs
`default_nettype wire

//--- verification/acd_top_props.sv
// Purpose: Port checker for acd_top
// Assumes: Channel 0 is N, RW bits per ratio
// Notes:   Bound after the module
`timescale 1ns/1ps
`default_nettype none
module acd_top_props #(parameter int RW = 10) (
  input wire logic                          mclk,
  input wire logic                          reset_n,
  input wire logic                          clk_en,
  input wire acd_pkg::acd_req_t             req,
  input wire logic [7:0]                    rdata,
  input wire logic                          rvalid,
  input wire logic                          auto_detect_en,
  input wire logic [acd_pkg::ACD_CH*RW-1:0] auto_ratio,
  input wire logic [acd_pkg::ACD_CH-1:0]    div_tick,
  input wire logic [acd_pkg::ACD_CH-1:0]    div_clk,
  input wire logic [acd_pkg::ACD_CH*RW-1:0] div_ratio
);
  import acd_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  wire logic          rd_go    = clk_en && req.rd_en;
  wire logic          mapped   = req.addr inside {[8'h39:8'h3D], 8'h44, 8'h45};
  wire logic          lo_wr    = clk_en && req.wr_en && req.addr == 8'h3C;
  wire logic          lo_rd    = rd_go && !req.wr_en && req.addr == 8'h3C;
  wire logic          auto_go  = clk_en && auto_detect_en;
  wire logic [RW-1:0] n_ratio  = div_ratio[RW-1:0];
  wire logic [RW-1:0] ar0      = (auto_ratio[RW-1:0] == '0) ? RW'(1) : auto_ratio[RW-1:0];
  wire logic          two_tick = clk_en && div_tick[0] && n_ratio == RW'(2);
  a_read_answers: assert property (rd_go |=> rvalid)
    else $error("read got no answer");
  a_answer_cause: assert property (rvalid |-> $past(rd_go) || !$past(clk_en))
    else $error("answer without read");
  a_unmapped_zero: assert property (rd_go && !mapped |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rsvd_n_pdm: assert property (rd_go && req.addr == 8'h39 |=> rdata[1:0] == 2'h0)
    else $error("reserved bits set");
  a_rsvd_enable: assert property (rd_go && req.addr == 8'h44 |=> rdata[7:3] == 5'h00)
    else $error("reserved enable bits set");
  a_low_readback: assert property (lo_wr ##1 lo_rd |=> rdata == $past(req.wdata, 2))
    else $error("low byte readback wrong");
  a_auto_ratio: assert property (auto_go |=> n_ratio == $past(ar0))
    else $error("auto ratio not applied");
  a_tick_two: assert property (two_tick ##1 n_ratio == RW'(2) |-> !div_tick[0])
    else $error("tick spacing wrong");
  cover property (rd_go && !mapped);
  cover property (auto_detect_en && div_tick[0]);
  cover property (div_tick[5]);
endmodule : acd_top_props
bind acd_top acd_top_props #(.RW(RW)) acd_top_props_inst (.mclk(mclk), .reset_n(reset_n),
  .clk_en(clk_en), .req(req), .rdata(rdata), .rvalid(rvalid), .auto_detect_en(auto_detect_en),
  .auto_ratio(auto_ratio), .div_tick(div_tick), .div_clk(div_clk), .div_ratio(div_ratio));
`default_nettype wire

//--- verification/acd_top_bench.sv
// Purpose: Self-checking bench for acd_top
// Assumes: Inputs driven at falling edge
// Notes:   RW is ten
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module acd_top_bench;
  import acd_pkg::*;
  logic                 mclk;
  logic                 reset_n;
  logic                 clk_en;
  logic                 auto_detect_en;
  acd_req_t             req;
  logic [7:0]           rdata;
  logic                 rvalid;
  logic [ACD_CH*10-1:0] auto_ratio;
  logic [ACD_CH*10-1:0] div_ratio;
  logic [ACD_CH-1:0]    div_tick;
  logic [ACD_CH-1:0]    div_clk;
  int                   n_mismatch;
  int                   num_checks;
  acd_top #(.RW(10)) acd_top_inst (.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en),
    .req(req), .rdata(rdata), .rvalid(rvalid), .auto_detect_en(auto_detect_en),
    .auto_ratio(auto_ratio), .div_tick(div_tick), .div_clk(div_clk), .div_ratio(div_ratio));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req = '{1'b1, 1'b0, a, d};
    @(negedge mclk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge mclk);
    `CHK("rvalid", 1'b1, rvalid)
    `CHK("rdata", e, rdata)
  endtask : rd
  task automatic idle(input int n);
    req = '0;
    repeat (n) @(negedge mclk);
  endtask : idle
  task automatic cr(input int ch, input acd_ratio_t e);
    idle(2);
    `CHK("ratio", e, div_ratio[ch*10+:10])
  endtask : cr
  task automatic ct(input int ch, input int e, input int ec);
    int n;
    int k;
    n = 0;
    k = 0;
    repeat (30) begin
      @(negedge mclk);
      if (div_tick[ch] === 1'b1) n++;
      if (div_clk[ch] === 1'b1) k++;
    end
    `CHK("ticks", e, n)
    `CHK("clk high", ec, k)
  endtask : ct
  task automatic t_reset;
    rd(8'h39, 8'h20);
    rd(8'h3A, 8'h04);
    rd(8'h3B, 8'h00);
    rd(8'h3C, 8'h01);
    rd(8'h3D, 8'h01);
    rd(8'h44, 8'h00);
    rd(8'h45, 8'h00);
    rd(8'h50, 8'h00);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_reserved;
    wr(8'h39, 8'hFF);
    rd(8'h39, 8'hFC);
    wr(8'h3B, 8'hFF);
    rd(8'h3B, 8'h36);
    wr(8'h44, 8'hFF);
    rd(8'h44, 8'h07);
    wr(8'h3C, 8'hA5);
    rd(8'h3C, 8'hA5);
    $display("t_reserved done");
  endtask : t_reserved
  task automatic t_fields;
    int m[3] = '{0, 1, 63};
    wr(8'h45, 8'hFF);
    for (int i = 0; i < 8; i++) begin
      wr(8'h39, 8'(i << 5));
      cr(0, (i == 0) ? 10'd8 : 10'(i));
    end
    for (int i = 0; i < 5; i++) begin
      wr(8'h39, 8'(i << 2));
      cr(2, 10'(1 << i));
    end
    foreach (m[i]) begin
      wr(8'h3A, 8'(m[i] << 2));
      cr(1, (m[i] == 0) ? 10'd64 : 10'(m[i]));
    end
    for (int i = 0; i < 3; i++) begin
      wr(8'h3A, 8'(4 | i));
      cr(3, 10'(1 << i));
      wr(8'h3B, 8'(i << 4));
      cr(4, 10'(1 << i));
    end
    wr(8'h3B, 8'h00);
    wr(8'h3C, 8'h00);
    wr(8'h3D, 8'h00);
    cr(5, 10'd512);
    cr(6, 10'd512);
    wr(8'h3B, 8'h06);
    wr(8'h3C, 8'h05);
    wr(8'h3D, 8'h03);
    cr(5, 10'h105);
    cr(6, 10'h103);
    $display("t_fields done");
  endtask : t_fields
  task automatic t_tick;
    wr(8'h39, 8'h40);
    idle(2);
    ct(0, 15, 15);
    wr(8'h44, 8'h03);
    idle(2);
    ct(0, 0, 0);
    wr(8'h44, 8'h07);
    wr(8'h39, 8'h54);
    idle(2);
    ct(2, 0, 0);
    wr(8'h3A, 8'h07);
    idle(2);
    ct(3, 0, 0);
    wr(8'h3B, 8'h36);
    idle(2);
    ct(4, 0, 0);
    $display("t_tick done");
  endtask : t_tick
  task automatic t_auto;
    auto_detect_en = 1'b1;
    auto_ratio[9:0] = 10'd5;
    cr(0, 10'd5);
    wr(8'h39, 8'h60);
    cr(0, 10'd5);
    auto_detect_en = 1'b0;
    idle(2);
    $display("t_auto done");
  endtask : t_auto
  task automatic t_freeze;
    clk_en = 1'b0;
    wr(8'h3C, 8'h77);
    cr(5, 10'h105);
    clk_en = 1'b1;
    rd(8'h3C, 8'h05);
    $display("t_freeze done");
  endtask : t_freeze
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  initial begin
    repeat (5000) @(posedge mclk);
    n_mismatch++;
    stop_test();
  end
  initial begin
    reset_n = 1'b0;
    clk_en = 1'b1;
    req = '0;
    auto_detect_en = 1'b0;
    auto_ratio = '0;
    repeat (3) @(negedge mclk);
    reset_n = 1'b1;
    t_reset();
    t_reserved();
    t_fields();
    t_tick();
    t_auto();
    t_freeze();
    stop_test();
  end
endmodule : acd_top_bench
`default_nettype wire
